// File: rtl/spc_pd_timer.sv
// automatic power-down timer counted in whole seconds
// assumes a one-cycle tick every second; granularity is one second
`timescale 1ns/1ps
module spc_pd_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tick,
  spc_tmr_if.timer t
);
  logic [15:0] next_interval;
  logic [15:0] next_remain;
  logic next_enabled;
  logic next_expire;

  always_comb begin
    next_interval = t.interval;
    next_remain = t.remain;
    next_enabled = t.enabled;
    next_expire = 1'b0;
    if (t.load) begin
      next_interval = t.load_val;
      next_remain = t.load_val;
      next_enabled = (t.load_val != 16'h0);
    end else if (t.reload) begin
      next_remain = t.interval;
    end else if (t.run && t.enabled && tick && t.remain != 16'h0) begin
      next_remain = t.remain - 16'h1;
      next_expire = (t.remain == 16'h1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      t.interval <= 16'h0;
      t.remain <= 16'h0;
      t.enabled <= 1'b0;
      t.expire <= 1'b0;
    end else begin
      t.interval <= next_interval;
      t.remain <= next_remain;
      t.enabled <= next_enabled;
      t.expire <= next_expire;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  reload_full_a: assert property (t.reload && !t.load |=> t.remain == $past(t.interval))
    else $error("reload did not restore full interval");
endmodule : spc_pd_timer

// File: rtl/spc_pkg.sv
// constants, codes and timeout decoding for the standby command block
// assumes one 100 MHz clock; only the command engine and the testbench import this package whole
package spc_pkg;
  localparam int SPC_CLK_HZ = 100_000_000;
  localparam int SPC_SEC_S = 1;
  localparam int SPC_TICK_CYCLES = SPC_CLK_HZ * SPC_SEC_S;

  localparam logic [7:0] SPC_OP_STBY_A = 8'he2;
  localparam logic [7:0] SPC_OP_STBY_B = 8'h96;
  localparam logic [7:0] SPC_OP_IMM_A = 8'he0;
  localparam logic [7:0] SPC_OP_IMM_B = 8'h94;

  localparam logic [7:0] SPC_TO_DISABLED = 8'h00;
  localparam logic [7:0] SPC_TO_SEC_MAX = 8'hf0;
  localparam logic [7:0] SPC_TO_HALF_MAX = 8'hfb;
  localparam logic [7:0] SPC_TO_21M = 8'hfc;
  localparam logic [7:0] SPC_TO_8H = 8'hfd;
  localparam logic [7:0] SPC_TO_ABORT = 8'hfe;
  localparam logic [7:0] SPC_TO_21M15 = 8'hff;

  localparam logic [15:0] SPC_STEP_S = 16'h0005;
  localparam logic [15:0] SPC_STEP_HALF_S = 16'h0708;
  localparam logic [15:0] SPC_21M_S = 16'h04ec;
  localparam logic [15:0] SPC_8H_S = 16'h7080;
  localparam logic [15:0] SPC_21M15_S = 16'h04fb;

  localparam int SPC_ST_ERR = 0;
  localparam int SPC_ST_DSC = 4;
  localparam int SPC_ST_DF = 5;
  localparam int SPC_ST_RDY = 6;
  localparam int SPC_ST_BSY = 7;
  localparam int SPC_ER_ABT = 2;
  localparam logic [7:0] SPC_STATUS_RST = 8'h50;
  localparam logic [7:0] SPC_ERROR_RST = 8'h00;

  localparam logic [1:0] SPC_PWR_IDLE = 2'h0;
  localparam logic [1:0] SPC_PWR_STBY = 2'h1;
  localparam logic [1:0] SPC_PWR_STBY_Z = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SPIN_DOWN, ST_STANDBY, ST_SPIN_UP} spc_state_e;

  // timeout code to seconds; zero and the abort code give zero
  function automatic logic [15:0] spc_to_seconds(input logic [7:0] code);
    logic [15:0] v;
    v = {8'h00, code};
    if (code == SPC_TO_DISABLED || code == SPC_TO_ABORT) begin
      return 16'h0000;
    end else if (code <= SPC_TO_SEC_MAX) begin
      return 16'(v * SPC_STEP_S);
    end else if (code <= SPC_TO_HALF_MAX) begin
      return 16'((v - {8'h00, SPC_TO_SEC_MAX}) * SPC_STEP_HALF_S);
    end else if (code == SPC_TO_21M) begin
      return SPC_21M_S;
    end else if (code == SPC_TO_8H) begin
      return SPC_8H_S;
    end else begin
      return SPC_21M15_S;
    end
  endfunction : spc_to_seconds

  function automatic logic spc_is_stby(input logic [7:0] op);
    return op == SPC_OP_STBY_A || op == SPC_OP_STBY_B;
  endfunction : spc_is_stby

  function automatic logic spc_is_imm(input logic [7:0] op);
    return op == SPC_OP_IMM_A || op == SPC_OP_IMM_B;
  endfunction : spc_is_imm
endpackage : spc_pkg

// File: rtl/spc_sec_tick.sv
// one-second enable pulse divided down from ref_clk
// assumes CYCLES of at least two
`timescale 1ns/1ps
module spc_sec_tick #(
  parameter int CYCLES = 100
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_tick = (cnt == 32'(CYCLES - 1));
    next_cnt = next_tick ? 32'h0 : cnt + 32'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : spc_sec_tick

// File: rtl/spc_standby_cmd.sv
// standby and immediate-standby command engine with auto power-down
// assumes task-file commands arrive as one-cycle strobes on ref_clk and
// spindle status inputs are synchronous to ref_clk
`timescale 1ns/1ps
module spc_standby_cmd
  import spc_pkg::*;
#(
  parameter int TICK_CYCLES = SPC_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_count,
  output logic cmd_ready,
  output logic cmd_done,
  output logic [7:0] status,
  output logic [7:0] error,
  input wire logic host_access,
  input wire logic media_req,
  output logic media_go,
  input wire logic epc_enable,
  input wire logic spindle_stopped,
  input wire logic spindle_at_speed,
  output logic spin_down_req,
  output logic spin_up_req,
  output logic [1:0] pwr_state,
  output logic timer_enabled
);
  spc_tmr_if tmr ();
  logic tick;

  spc_sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  spc_pd_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .t(tmr)
  );

  spc_state_e state;
  spc_state_e next_state;
  logic deep;
  logic next_deep;
  logic next_done;
  logic [7:0] next_status;
  logic [7:0] next_error;
  logic next_spin_down;
  logic [1:0] next_pwr;
  logic take;
  logic is_stby;
  logic is_imm;
  logic bad_to;
  logic go_standby;
  logic woke;

  // one idle cycle after each completion keeps a new command off the done pulse
  assign cmd_ready = !cmd_done;
  assign take = cmd_valid && cmd_ready;
  assign is_stby = spc_is_stby(cmd_code);
  assign is_imm = spc_is_imm(cmd_code);
  assign bad_to = is_stby && cmd_count == SPC_TO_ABORT;
  assign media_go = media_req && state == ST_IDLE && spindle_at_speed;
  assign woke = state == ST_SPIN_UP && spindle_at_speed;
  assign timer_enabled = tmr.enabled;
  assign spin_up_req = state == ST_SPIN_UP;

  always_comb begin
    tmr.load = take && is_stby && !bad_to;
    tmr.load_val = spc_to_seconds(cmd_count);
    tmr.reload = host_access || take || media_go || woke;
    tmr.run = state == ST_IDLE;
  end

  always_comb begin
    next_state = state;
    next_deep = deep;
    next_done = 1'b0;
    next_status = status;
    next_error = error;
    next_spin_down = 1'b0;
    go_standby = (take && (is_imm || (is_stby && !bad_to))) ||
                 (!take && state == ST_IDLE && tmr.expire && !media_req);
    if (go_standby) begin
      next_deep = epc_enable;
      if (spindle_stopped) begin
        next_state = ST_STANDBY;
      end else begin
        next_state = ST_SPIN_DOWN;
        next_spin_down = 1'b1;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_SPIN_DOWN: begin
          if (media_req) begin
            next_state = ST_SPIN_UP;
          end else if (spindle_stopped) begin
            next_state = ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (media_req) begin
            next_state = ST_SPIN_UP;
          end
        end
        ST_SPIN_UP: begin
          if (spindle_at_speed) begin
            next_state = ST_IDLE;
            next_deep = 1'b0;
          end
        end
      endcase
    end
    if (take) begin
      next_done = 1'b1;
      if (bad_to) begin
        next_status = SPC_STATUS_RST | (8'h01 << SPC_ST_ERR);
        next_error = 8'h01 << SPC_ER_ABT;
      end else if (is_stby || is_imm) begin
        next_status = SPC_STATUS_RST;
        next_error = SPC_ERROR_RST;
      end
    end
    if (next_state == ST_IDLE || next_state == ST_SPIN_UP) begin
      next_pwr = SPC_PWR_IDLE;
    end else begin
      next_pwr = next_deep ? SPC_PWR_STBY_Z : SPC_PWR_STBY;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      deep <= 1'b0;
      cmd_done <= 1'b0;
      status <= SPC_STATUS_RST;
      error <= SPC_ERROR_RST;
      spin_down_req <= 1'b0;
      pwr_state <= SPC_PWR_IDLE;
    end else begin
      state <= next_state;
      deep <= next_deep;
      cmd_done <= next_done;
      status <= next_status;
      error <= next_error;
      spin_down_req <= next_spin_down;
      pwr_state <= next_pwr;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence stby_take_s;
    take && is_stby && !bad_to;
  endsequence

  timer_load_a: assert property (stby_take_s |=> tmr.interval == spc_to_seconds($past(cmd_count)))
    else $error("timeout not loaded from sector count");
  standby_now_a: assert property (stby_take_s |=> pwr_state != SPC_PWR_IDLE)
    else $error("standby command did not enter standby");
  spin_down_a: assert property (take && is_imm && !spindle_stopped |=> spin_down_req ##1 !spin_down_req)
    else $error("spin-down not requested once");
  skip_spin_a: assert property (take && is_imm && spindle_stopped |=> !spin_down_req && state == ST_STANDBY)
    else $error("spin-down issued on stopped spindle");
  imm_keeps_a: assert property (take && is_imm |=> $stable(tmr.interval))
    else $error("immediate standby changed timeout");
  deep_stby_a: assert property (go_standby && epc_enable |=> pwr_state == SPC_PWR_STBY_Z)
    else $error("deep standby not entered");
  media_hold_a: assert property (media_go |-> spindle_at_speed && pwr_state == SPC_PWR_IDLE)
    else $error("media access before full speed");
  idle_count_a: assert property (tmr.remain != $past(tmr.remain) && !$past(tmr.load) && !$past(tmr.reload)
    |-> $past(state) == ST_IDLE)
    else $error("timer counted outside idle");
  auto_stby_a: assert property (tmr.expire && state == ST_IDLE && !take && !media_req
    |=> state inside {ST_SPIN_DOWN, ST_STANDBY})
    else $error("expiry did not enter standby");
  abort_code_a: assert property (take && bad_to |=> cmd_done && error == 8'h04 && status == 8'h51
    ##1 !cmd_done && state == $past(state, 2))
    else $error("abort code not reported");
  done_ok_a: assert property (take && is_imm |=> cmd_done && !status[SPC_ST_BSY] && !status[SPC_ST_DF]
    && status[SPC_ST_RDY] && !status[SPC_ST_ERR])
    else $error("completion status wrong");

  done_pulse_a: assert property (take |=> cmd_done ##1 !cmd_done)
    else $error("done pulse wrong");

  stray_done_a: assert property (!take |=> !cmd_done)
    else $error("done without command");

  good_status_a: assert property (stby_take_s |=> status == SPC_STATUS_RST && error == SPC_ERROR_RST)
    else $error("good standby status wrong");

  abort_no_load_a: assert property (take && bad_to |=> $stable(tmr.interval) && $stable(tmr.enabled))
    else $error("aborted command touched timer");

  abort_no_spin_a: assert property (take && bad_to |=> !spin_down_req)
    else $error("aborted command spun down");

  stby_spin_a: assert property (stby_take_s && !spindle_stopped |=> spin_down_req)
    else $error("standby did not request spin-down");

  stby_skip_a: assert property (stby_take_s && spindle_stopped |=> !spin_down_req && state == ST_STANDBY)
    else $error("standby spun down a stopped spindle");

  imm_now_a: assert property (take && is_imm |=> pwr_state != SPC_PWR_IDLE)
    else $error("immediate standby not entered");

  plain_stby_a: assert property (go_standby && !epc_enable |=> pwr_state == SPC_PWR_STBY)
    else $error("plain standby not entered");

  spin_up_wait_a: assert property (state == ST_SPIN_UP && !spindle_at_speed && !go_standby
    |=> state == ST_SPIN_UP && spin_up_req)
    else $error("left spin-up before full speed");

  wake_start_a: assert property (state == ST_STANDBY && media_req && !go_standby |=> spin_up_req)
    else $error("media request did not spin up");

  no_media_stby_a: assert property (pwr_state != SPC_PWR_IDLE |-> !media_go)
    else $error("media released in standby");

  wake_idle_a: assert property (state == ST_SPIN_UP && spindle_at_speed && !go_standby
    |=> pwr_state == SPC_PWR_IDLE && state == ST_IDLE)
    else $error("did not return to idle at speed");

  zero_off_a: assert property (take && is_stby && cmd_count == SPC_TO_DISABLED |=> !timer_enabled)
    else $error("zero timeout left timer on");

  nonzero_on_a: assert property (stby_take_s && cmd_count != SPC_TO_DISABLED |=> timer_enabled)
    else $error("nonzero timeout left timer off");

  sec_step_a: assert property (stby_take_s && cmd_count == 8'h01 |=> tmr.interval == SPC_STEP_S)
    else $error("first code not five seconds");

  half_step_a: assert property (stby_take_s && cmd_count == 8'hf1 |=> tmr.interval == SPC_STEP_HALF_S)
    else $error("first half hour code wrong");

  code_21m_a: assert property (stby_take_s && cmd_count == SPC_TO_21M |=> tmr.interval == SPC_21M_S)
    else $error("21 minute code wrong");

  code_8h_a: assert property (stby_take_s && cmd_count == SPC_TO_8H |=> tmr.interval == SPC_8H_S)
    else $error("8 hour code wrong");

  code_21m15_a: assert property (stby_take_s && cmd_count == SPC_TO_21M15 |=> tmr.interval == SPC_21M15_S)
    else $error("21 minute 15 second code wrong");

  host_reload_a: assert property (host_access && !tmr.load |=> tmr.remain == tmr.interval)
    else $error("host access did not reload timer");

  hold_in_stby_a: assert property (state == ST_STANDBY && !tmr.load && !tmr.reload |=> $stable(tmr.remain))
    else $error("timer counted in standby");

  expire_spin_a: assert property (tmr.expire && state == ST_IDLE && !take && !media_req && !spindle_stopped
    |=> spin_down_req)
    else $error("expiry did not request spin-down");

  auto_stby_c: cover property (tmr.expire ##1 state == ST_SPIN_DOWN);
  wake_c: cover property (state == ST_STANDBY ##[1:20] media_go);
  abort_c: cover property (take && bad_to);
  imm_stopped_c: cover property (take && is_imm && spindle_stopped);
  deep_c: cover property (pwr_state == SPC_PWR_STBY_Z);
endmodule : spc_standby_cmd

// File: rtl/spc_tmr_if.sv
// power-down timer link between the command engine and its timer
// assumes both ends run on ref_clk
`timescale 1ns/1ps
interface spc_tmr_if;
  logic load;
  logic [15:0] load_val;
  logic reload;
  logic run;
  logic [15:0] interval;
  logic [15:0] remain;
  logic enabled;
  logic expire;
  modport engine (output load, load_val, reload, run, input interval, remain, enabled, expire);
  modport timer (input load, load_val, reload, run, output interval, remain, enabled, expire);
endinterface : spc_tmr_if

// File: test/spc_spindle_model.sv
// spindle motor stand-in for the standby command block
// assumes registered requests on ref_clk; DELAY sets spin-down and spin-up time
`timescale 1ns/1ps
module spc_spindle_model #(
  parameter int DELAY = 6
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spin_down_req,
  input wire logic spin_up_req,
  output logic spindle_stopped,
  output logic spindle_at_speed
);
  int cnt;
  // no instant answers: the engine must wait out the spin time both ways
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      spindle_stopped <= 1'b0;
      spindle_at_speed <= 1'b1;
      cnt <= 0;
    end else if (spin_down_req) begin
      spindle_at_speed <= 1'b0;
      cnt <= DELAY;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (spin_up_req && !spindle_at_speed) begin
      if (spindle_stopped) begin
        spindle_stopped <= 1'b0;
        cnt <= DELAY;
      end else begin
        spindle_at_speed <= 1'b1;
      end
    end else if (!spindle_at_speed) begin
      spindle_stopped <= 1'b1;
    end
  end
endmodule : spc_spindle_model

// File: test/testbench.sv
// self-checking bench for the standby command engine
// assumes a spindle stand-in at the far side and a 10-cycle second tick
`timescale 1ns/1ps
module testbench;
  import spc_pkg::*;
  localparam int TICK = 10;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] count;
    logic epc;
    logic [1:0] pwr;
    logic [7:0] st;
    logic [7:0] er;
    logic ten;
  } spc_row_s;
  // each row starts from idle with the spindle running
  spc_row_s rows [8] = '{
    '{8'he2, 8'h0c, 1'b0, 2'h1, 8'h50, 8'h00, 1'b1},
    '{8'he0, 8'h00, 1'b0, 2'h1, 8'h50, 8'h00, 1'b1},
    '{8'h96, 8'h00, 1'b0, 2'h1, 8'h50, 8'h00, 1'b0},
    '{8'h94, 8'h05, 1'b1, 2'h2, 8'h50, 8'h00, 1'b0},
    '{8'he2, 8'hfe, 1'b0, 2'h0, 8'h51, 8'h04, 1'b0},
    '{8'h96, 8'hff, 1'b1, 2'h2, 8'h50, 8'h00, 1'b1},
    '{8'hec, 8'h00, 1'b0, 2'h0, 8'h50, 8'h00, 1'b1},
    '{8'he2, 8'hfc, 1'b0, 2'h1, 8'h50, 8'h00, 1'b1}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [7:0] cmd_count = 8'h00;
  logic host_access = 1'b0;
  logic media_req = 1'b0;
  logic epc_enable = 1'b0;
  logic cmd_ready, cmd_done, media_go, spindle_stopped, spindle_at_speed;
  logic spin_down_req, spin_up_req, timer_enabled;
  logic [7:0] status, error;
  logic [1:0] pwr_state;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  spc_standby_cmd #(.TICK_CYCLES(TICK)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_count(cmd_count), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .status(status), .error(error), .host_access(host_access), .media_req(media_req),
    .media_go(media_go), .epc_enable(epc_enable), .spindle_stopped(spindle_stopped),
    .spindle_at_speed(spindle_at_speed), .spin_down_req(spin_down_req), .spin_up_req(spin_up_req),
    .pwr_state(pwr_state), .timer_enabled(timer_enabled));
  spc_spindle_model spindle (.ref_clk(ref_clk), .rst_n(rst_n), .spin_down_req(spin_down_req),
    .spin_up_req(spin_up_req), .spindle_stopped(spindle_stopped), .spindle_at_speed(spindle_at_speed));

  always #5 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // whole run is a few hundred cycles; this only cuts a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // leaves the bench in the cycle after the take, where cmd_done stands
  task automatic send(input logic [7:0] code, input logic [7:0] count);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_count = count;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : send

  task automatic wake();
    n = 0;
    media_req = 1'b1;
    while (media_go !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(media_go, 16'h0001);
    chk(spindle_at_speed, 16'h0001);
    chk(pwr_state, SPC_PWR_IDLE);
    @(posedge ref_clk);
    #1;
    media_req = 1'b0;
  endtask : wake

  // first tick may land up to one second early, hence the lower bound
  task automatic wait_auto();
    n = 0;
    while (pwr_state === SPC_PWR_IDLE && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(16'(n >= 4 * TICK && n <= 6 * TICK + 5), 16'h0001);
    chk(pwr_state, SPC_PWR_STBY);
  endtask : wait_auto

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk(status, SPC_STATUS_RST);
    chk(error, SPC_ERROR_RST);
    chk(pwr_state, SPC_PWR_IDLE);
    $display("test reset done");
    foreach (rows[i]) begin
      epc_enable = rows[i].epc;
      send(rows[i].code, rows[i].count);
      chk(cmd_done, 16'h0001);
      chk(cmd_ready, 16'h0000);
      chk(spin_down_req, 16'(rows[i].pwr != 2'h0));
      chk(pwr_state, rows[i].pwr);
      chk(status, rows[i].st);
      chk(error, rows[i].er);
      chk(timer_enabled, rows[i].ten);
      wake();
      $display("test row %0d done", i);
    end
    epc_enable = 1'b0;
    send(SPC_OP_STBY_A, 8'h00);
    n = 0;
    while (spindle_stopped !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    send(SPC_OP_IMM_B, 8'h00);
    chk(spin_down_req, 16'h0000);
    chk(pwr_state, SPC_PWR_STBY);
    chk(cmd_done, 16'h0001);
    wake();
    $display("test stopped spindle done");
    send(SPC_OP_STBY_B, 8'h01);
    wake();
    repeat (10) begin
      repeat (29) @(posedge ref_clk);
      #1;
      host_access = 1'b1;
      @(posedge ref_clk);
      #1;
      host_access = 1'b0;
    end
    chk(pwr_state, SPC_PWR_IDLE);
    wait_auto();
    $display("test auto standby done");
    report_and_stop();
  end
endmodule : testbench
